// *** dv/crf_checker.sv ***
/*
  Checker for crf_core: flag updates, decode answers and pair view.
  Assumes it is bound to crf_core and shares its clock and reset.
*/
`default_nettype none

module crf_checker
  import crf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire crf_wr_t exe_wr,
  input wire crf_alu_t exe_alu,
  input wire crf_view_t exe_view,
  input wire logic map_req,
  input wire logic [19:0] map_addr,
  input wire logic sfr_assigned,
  input wire crf_region_t map_region,
  input wire logic map_grant
);
  timeunit 1ns;
  timeprecision 1ns;
  logic want_z;
  logic want_s;
  logic [10:0] fl;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Byte operations judge the low byte only
  assign want_z = exe_alu.byte_op ? exe_alu.result[7:0] == 8'h00 : exe_alu.result == 16'h0000;
  assign want_s = exe_alu.byte_op ? exe_alu.result[7] : exe_alu.result[15];
  assign fl = exe_view.status_flags;

  property p_zero;
    exe_alu.valid |=> fl[FLAG_ZERO] == $past(want_z);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");
  property p_sign;
    exe_alu.valid |=> fl[FLAG_SIGN] == $past(want_s);
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign flag wrong");
  property p_carry;
    exe_alu.valid |=> fl[FLAG_CARRY] == $past(exe_alu.carry);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry flag wrong");
  property p_ovf;
    exe_alu.valid |=> fl[FLAG_OVERFLOW] == $past(exe_alu.overflow);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flag wrong");
  property p_vec;
    map_req && map_addr >= VECTOR_LOW && map_addr <= VECTOR_HIGH
      |=> map_region == CRF_REGION_VECTOR && map_grant;
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector table decode wrong");
  property p_sfr;
    map_req && map_addr <= SFR_HIGH
      |=> map_region == CRF_REGION_SFR && map_grant == $past(sfr_assigned);
  endproperty
  a_sfr: assert property (p_sfr)
    else $error("peripheral window decode wrong");
  property p_hold;
    !map_req |=> $stable(map_region) && $stable(map_grant);
  endproperty
  a_hold: assert property (p_hold)
    else $error("decode answer moved without request");
  property p_pair;
    reg_wr && reg_addr == 8'h44 && !exe_wr.valid |=> exe_view.data_pair_even == $past(reg_wdata);
  endproperty
  a_pair: assert property (p_pair)
    else $error("even pair view wrong");

  // Main scenarios reached
  c_vec: cover property (map_req && map_addr == VECTOR_HIGH);
  c_byte: cover property (exe_alu.valid && exe_alu.byte_op);
  c_pair: cover property (reg_wr && reg_addr == 8'h44);
endmodule : crf_checker

`default_nettype wire

// *** dv/crf_exe_model.sv ***
/*
  Stand-in for the execution datapath: one-cycle register writes and
  arithmetic results. Assumes the register file samples on clk_sys.
*/
`default_nettype none

module crf_exe_model
  import crf_pkg::*;
(
  input wire logic clk_sys,
  output crf_wr_t exe_wr,
  output crf_alu_t exe_alu
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle until a task is called
  initial begin
    exe_wr = '0;
    exe_alu = '0;
  end

  // One-cycle result pulse
  task automatic alu(input logic [15:0] res, input logic bop, c, o);
    @(posedge clk_sys);
    exe_alu <= '{1'b1, bop, res, c, o};
    @(posedge clk_sys);
    exe_alu.valid <= 1'b0;
  endtask : alu

  task automatic wr(input logic [4:0] sel, input logic [31:0] d);
    @(posedge clk_sys);
    exe_wr <= '{1'b1, sel, sel == IDX_STATUS_FLAGS ? d & 32'hFFFF_FFFD : d};
    @(posedge clk_sys);
    exe_wr.valid <= 1'b0;
  endtask : wr
endmodule : crf_exe_model

`default_nettype wire

// *** dv/tb.sv ***
/*
  Top testbench for crf_core: register port, datapath stand-in, decode.
  Assumes crf_pkg, crf_core, crf_exe_model and crf_checker are compiled.
*/
`default_nettype none

module tb
  import crf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] q;
  crf_wr_t exe_wr;
  crf_alu_t exe_alu;
  crf_view_t exe_view;
  logic map_req = 1'b0;
  logic [19:0] map_addr = 20'h0_0000;
  logic sfr_assigned = 1'b0;
  crf_region_t map_region;
  logic map_grant;
  int num_errors = 0;
  int cmp_count = 0;

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  crf_core dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exe_wr(exe_wr),
    .exe_alu(exe_alu), .exe_view(exe_view), .map_req(map_req), .map_addr(map_addr),
    .sfr_assigned(sfr_assigned), .map_region(map_region), .map_grant(map_grant)
  );
  crf_exe_model u_exe (.clk_sys(clk_sys), .exe_wr(exe_wr), .exe_alu(exe_alu));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [4:0] idx, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= {1'b0, idx, 2'b00};
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] idx);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= {1'b0, idx, 2'b00};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd

  task automatic af(input logic [15:0] r, input logic b, c, o, input logic [31:0] e);
    u_exe.alu(r, b, c, o);
    rd(IDX_STATUS_FLAGS);
    chk(q, e);
  endtask : af

  task automatic t_regs;
    for (logic [4:0] i = 5'h00; i < 5'h0c; i++) begin
      rd(i);
      chk(q, 32'h0000_0000);
      wr(i, 32'hFFFF_FF00 | {27'h0, i});
      rd(i);
      if (i == 5'h08 || i == 5'h09) begin
        chk(q, 32'h000F_FF00 | {27'h0, i});
      end else begin
        chk(q, 32'h0000_FF00 | {27'h0, i});
      end
    end
    rd(5'h14);
    chk(q, 32'h0000_FF0B);
    wr(5'h15, 32'h0000_1234);
    rd(5'h15);
    chk(q, 32'h0000_0000);
    // Datapath view of the same registers, settled after the read
    chk({12'h000, exe_view.vector_table_base}, 32'h000F_FF08);
    chk({12'h000, exe_view.program_counter}, 32'h000F_FF09);
    chk({16'h0000, exe_view.active_sp}, 32'h0000_FF0B);
    chk({exe_view.frame_base, exe_view.static_base}, 32'hFF06_FF07);
  endtask : t_regs

  // byte halves keep the other half
  task automatic t_bytes;
    logic [4:0] lo;
    for (logic [4:0] r = 5'h00; r < 5'h02; r++) begin
      lo = r[0] ? IDX_DATA_REG_1_LOW_BYTE : IDX_DATA_REG_0_LOW_BYTE;
      wr(r, 32'h0000_A1B2);
      wr(lo, 32'hFFFF_FFC3);
      rd(r);
      chk(q, 32'h0000_A1C3);
      wr(lo + 5'h01, 32'h0000_00D4);
      rd(r);
      chk(q, 32'h0000_D4C3);
      rd(lo + 5'h01);
      chk(q, 32'h0000_00D4);
    end
  endtask : t_bytes

  task automatic t_pairs;
    logic [4:0] lo [3] = '{5'h00, 5'h01, 5'h04};
    logic [4:0] hi [3] = '{5'h02, 5'h03, 5'h05};
    logic [31:0] v;
    for (int p = 0; p < 3; p++) begin
      wr(5'h11 + p[4:0], 32'hA5A5_5A5A ^ p);
    end
    for (int p = 0; p < 3; p++) begin
      v = 32'hA5A5_5A5A ^ p;
      rd(lo[p]);
      chk(q, {16'h0000, v[15:0]});
      rd(hi[p]);
      chk(q, {16'h0000, v[31:16]});
      rd(5'h11 + p[4:0]);
      chk(q, v);
    end
    // Pair views towards the datapath
    chk(exe_view.data_pair_odd, 32'hA5A5_5A5B);
    chk(exe_view.address_pair, 32'hA5A5_5A58);
  endtask : t_pairs

  task automatic t_bank;
    wr(5'h00, 32'h0000_1111);
    wr(5'h0c, 32'hFFFF_FFFD);
    rd(5'h0c);
    chk(q, 32'h0000_07FD);
    rd(5'h00);
    chk(q, 32'h0000_0000);
    wr(5'h00, 32'h0000_2222);
    rd(5'h14);
    chk(q, 32'h0000_FF0A);
    wr(5'h0c, 32'h0000_0000);
    rd(5'h00);
    chk(q, 32'h0000_1111);
  endtask : t_bank

  task automatic t_alu;
    af(16'h0000, 1'b0, 1'b1, 1'b0, 32'h0000_0005);
    af(16'h8000, 1'b0, 1'b0, 1'b1, 32'h0000_0028);
    af(16'h0100, 1'b1, 1'b0, 1'b0, 32'h0000_0004);
    af(16'h0080, 1'b1, 1'b1, 1'b0, 32'h0000_0009);
    af(16'h7FFF, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    u_exe.wr(IDX_PROGRAM_COUNTER, 32'hFFF1_2345);
    rd(IDX_PROGRAM_COUNTER);
    chk(q, 32'h0001_2345);
    // Same-cycle writes: the datapath wins over software
    fork
      wr(IDX_STATIC_BASE, 32'h0000_1111);
      u_exe.wr(IDX_STATIC_BASE, 32'h0000_2222);
    join
    rd(IDX_STATIC_BASE);
    chk(q, 32'h0000_2222);
  endtask : t_alu

  task automatic t_map;
    logic [19:0] ad [14] = '{20'h0_FFDC, 20'h0_FFFF, 20'h0_FFDB, 20'h0_4000, 20'h0_3FFF,
      20'h0_0400, 20'h0_0DFF, 20'h0_0E00, 20'h0_0000, 20'h0_02FF, 20'h0_0300,
      20'h2_0000, 20'h2_3FFF, 20'hF_FFFF};
    crf_region_t rg [14] = '{CRF_REGION_VECTOR, CRF_REGION_VECTOR, CRF_REGION_ROM,
      CRF_REGION_ROM, CRF_REGION_UNMAPPED, CRF_REGION_RAM, CRF_REGION_RAM,
      CRF_REGION_UNMAPPED, CRF_REGION_SFR, CRF_REGION_SFR, CRF_REGION_UNMAPPED,
      CRF_REGION_DEBUG, CRF_REGION_DEBUG, CRF_REGION_UNMAPPED};
    logic [13:0] as = 14'h0500;
    logic [13:0] gr = 14'h016F;
    for (int i = 0; i <= 14; i++) begin
      @(posedge clk_sys);
      map_req <= i < 14;
      map_addr <= ad[i % 14];
      sfr_assigned <= as[i % 14];
      #1;
      if (i > 0) begin
        chk({29'h0, map_region}, {29'h0, rg[i - 1]});
        chk({31'h0, map_grant}, {31'h0, gr[i - 1]});
      end
    end
  endtask : t_map

  // refused port addresses, read stands once
  task automatic t_port;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      reg_wr <= k < 2;
      reg_rd <= k >= 2;
      reg_addr <= k[0] ? 8'h80 : 8'h01;
      reg_wdata <= 32'h0000_5555;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, 32'h0000_0000);
    end
    rd(IDX_DATA_REG_0);
    chk(q, 32'h0000_1111);
    @(posedge clk_sys);
    #1 chk(reg_rdata, 32'h0000_0000);
  endtask : t_port

  // mid-run reset clears flags and bank
  task automatic t_rst;
    wr(IDX_STATUS_FLAGS, 32'h0000_0010);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(IDX_STATUS_FLAGS);
    chk(q, 32'h0000_0000);
    rd(IDX_DATA_REG_0);
    chk(q, 32'h0000_0000);
    chk(exe_view.address_pair, 32'h0000_0000);
  endtask : t_rst

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // Reset for three cycles, then each scenario
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    $display("t_regs done");
    t_bytes;
    $display("t_bytes done");
    t_pairs;
    $display("t_pairs done");
    t_bank;
    $display("t_bank done");
    t_alu;
    $display("t_alu done");
    t_map;
    $display("t_map done");
    t_port;
    $display("t_port done");
    t_rst;
    $display("t_rst done");
    report_and_stop;
  end

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #200000;
    num_errors++;
    report_and_stop;
  end
endmodule : tb

bind crf_core crf_checker u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exe_wr(exe_wr),
  .exe_alu(exe_alu), .exe_view(exe_view), .map_req(map_req), .map_addr(map_addr),
  .sfr_assigned(sfr_assigned), .map_region(map_region), .map_grant(map_grant)
);

`default_nettype wire

// *** rtl/crf_core.sv ***
/*
  Processor core register file with flag register and address decode.
  Holds two banks of data, address and frame base registers, the static
  base, vector table base, program counter, both stack pointers and the
  flags. Software reaches them over a plain strobe port; the execution
  datapath writes them and reports arithmetic results for the flags.
  Assumes the datapath and register port share clk_sys.
*/
// Local design decisions: the strobed register port and the register addresses.
`default_nettype none

module crf_core
  import crf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire crf_wr_t exe_wr,
  input wire crf_alu_t exe_alu,
  output crf_view_t exe_view,
  input wire logic map_req,
  input wire logic [19:0] map_addr,
  input wire logic sfr_assigned,
  output crf_region_t map_region,
  output logic map_grant
);

  logic [15:0] bank_regs [BANK_COUNT][BANKED_COUNT];
  logic [15:0] next_bank_regs [BANK_COUNT][BANKED_COUNT];
  logic [15:0] static_base;
  logic [15:0] next_static_base;
  logic [19:0] vector_table_base;
  logic [19:0] next_vector_table_base;
  logic [19:0] program_counter;
  logic [19:0] next_program_counter;
  logic [15:0] user_stack_pointer;
  logic [15:0] next_user_stack_pointer;
  logic [15:0] interrupt_stack_pointer;
  logic [15:0] next_interrupt_stack_pointer;
  logic [10:0] status_flags;
  logic [10:0] next_status_flags;
  crf_wr_t src [2];
  logic bank;
  logic [15:0] active_sp;
  logic [31:0] read_word;
  crf_region_t next_region;

  // Bank and stack choice come straight from the flag bits
  // bank flag select
  assign bank = status_flags[FLAG_BANK];
  assign active_sp = status_flags[FLAG_STACK_SEL] ? user_stack_pointer : interrupt_stack_pointer;

  // Software port turned into a write; misaligned or high addresses drop
  always_comb begin
    src[0].valid = reg_wr && (reg_addr[1:0] == 2'b00) && !reg_addr[7];
    src[0].sel = reg_addr[6:2];
    src[0].data = reg_wdata;
    src[1] = exe_wr;
  end

  // Next state: software write, then datapath write, then ALU flags
  always_comb begin
    next_bank_regs = bank_regs;
    next_static_base = static_base;
    next_vector_table_base = vector_table_base;
    next_program_counter = program_counter;
    next_user_stack_pointer = user_stack_pointer;
    next_interrupt_stack_pointer = interrupt_stack_pointer;
    next_status_flags = status_flags;
    // Later source wins: the datapath overrides a same-cycle software write
    for (int k = 0; k < 2; k++) begin
      if (src[k].valid) begin
        case (src[k].sel)
          IDX_DATA_REG_0: next_bank_regs[bank][0] = src[k].data[15:0];
          IDX_DATA_REG_1: next_bank_regs[bank][1] = src[k].data[15:0];
          IDX_DATA_REG_2: next_bank_regs[bank][2] = src[k].data[15:0];
          IDX_DATA_REG_3: next_bank_regs[bank][3] = src[k].data[15:0];
          IDX_ADDRESS_REG_0: next_bank_regs[bank][4] = src[k].data[15:0];
          IDX_ADDRESS_REG_1: next_bank_regs[bank][5] = src[k].data[15:0];
          IDX_FRAME_BASE: next_bank_regs[bank][6] = src[k].data[15:0];
          IDX_STATIC_BASE: next_static_base = src[k].data[15:0];
          IDX_VECTOR_TABLE_BASE: next_vector_table_base = src[k].data[19:0];
          IDX_PROGRAM_COUNTER: next_program_counter = src[k].data[19:0];
          IDX_USER_STACK_POINTER: next_user_stack_pointer = src[k].data[15:0];
          IDX_INTERRUPT_STACK_POINTER: next_interrupt_stack_pointer = src[k].data[15:0];
          IDX_STATUS_FLAGS: next_status_flags = src[k].data[10:0];
          IDX_DATA_REG_0_LOW_BYTE: next_bank_regs[bank][0][7:0] = src[k].data[7:0];
          IDX_DATA_REG_0_HIGH_BYTE: next_bank_regs[bank][0][15:8] = src[k].data[7:0];
          IDX_DATA_REG_1_LOW_BYTE: next_bank_regs[bank][1][7:0] = src[k].data[7:0];
          IDX_DATA_REG_1_HIGH_BYTE: next_bank_regs[bank][1][15:8] = src[k].data[7:0];
          IDX_DATA_PAIR_EVEN: begin
            next_bank_regs[bank][2] = src[k].data[31:16];
            next_bank_regs[bank][0] = src[k].data[15:0];
          end
          IDX_DATA_PAIR_ODD: begin
            next_bank_regs[bank][3] = src[k].data[31:16];
            next_bank_regs[bank][1] = src[k].data[15:0];
          end
          IDX_ADDRESS_PAIR: begin
            next_bank_regs[bank][5] = src[k].data[31:16];
            next_bank_regs[bank][4] = src[k].data[15:0];
          end
          // write lands in the selected stack
          IDX_ACTIVE_STACK_POINTER: begin
            if (status_flags[FLAG_STACK_SEL]) begin
              next_user_stack_pointer = src[k].data[15:0];
            end else begin
              next_interrupt_stack_pointer = src[k].data[15:0];
            end
          end
          default: ;
        endcase
      end
    end
    // Arithmetic result updates the four result flags last
    if (exe_alu.valid) begin
      next_status_flags[FLAG_CARRY] = exe_alu.carry;
      next_status_flags[FLAG_ZERO] = exe_alu.byte_op ? (exe_alu.result[7:0] == 8'h00)
                                                     : (exe_alu.result == 16'h0000);
      // sign from top bit of operand size
      next_status_flags[FLAG_SIGN] = exe_alu.byte_op ? exe_alu.result[7] : exe_alu.result[15];
      next_status_flags[FLAG_OVERFLOW] = exe_alu.overflow;
    end
  end

  // Banked registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int b = 0; b < BANK_COUNT; b++) begin
        for (int r = 0; r < BANKED_COUNT; r++) begin
          bank_regs[b][r] <= RESET_WORD;
        end
      end
    end else begin
      bank_regs <= next_bank_regs;
    end
  end

  // Unbanked pointers and bases
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      static_base <= RESET_WORD;
      vector_table_base <= RESET_ADDR;
      program_counter <= RESET_ADDR;
      user_stack_pointer <= RESET_WORD;
      interrupt_stack_pointer <= RESET_WORD;
    end else begin
      static_base <= next_static_base;
      vector_table_base <= next_vector_table_base;
      program_counter <= next_program_counter;
      user_stack_pointer <= next_user_stack_pointer;
      interrupt_stack_pointer <= next_interrupt_stack_pointer;
    end
  end

  // Flags; debug bit is stored as written, software keeps it at zero
  // stored, not forced
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_flags <= RESET_FLAGS;
    end else begin
      status_flags <= next_status_flags;
    end
  end

  // Read selection mirrors the write decode
  always_comb begin
    read_word = 32'h0000_0000;
    case (reg_addr[6:2])
      IDX_DATA_REG_0: read_word[15:0] = bank_regs[bank][0];
      IDX_DATA_REG_1: read_word[15:0] = bank_regs[bank][1];
      IDX_DATA_REG_2: read_word[15:0] = bank_regs[bank][2];
      IDX_DATA_REG_3: read_word[15:0] = bank_regs[bank][3];
      IDX_ADDRESS_REG_0: read_word[15:0] = bank_regs[bank][4];
      IDX_ADDRESS_REG_1: read_word[15:0] = bank_regs[bank][5];
      IDX_FRAME_BASE: read_word[15:0] = bank_regs[bank][6];
      IDX_STATIC_BASE: read_word[15:0] = static_base;
      IDX_VECTOR_TABLE_BASE: read_word[19:0] = vector_table_base;
      IDX_PROGRAM_COUNTER: read_word[19:0] = program_counter;
      IDX_USER_STACK_POINTER: read_word[15:0] = user_stack_pointer;
      IDX_INTERRUPT_STACK_POINTER: read_word[15:0] = interrupt_stack_pointer;
      IDX_STATUS_FLAGS: read_word[10:0] = status_flags;
      IDX_DATA_REG_0_LOW_BYTE: read_word[7:0] = bank_regs[bank][0][7:0];
      IDX_DATA_REG_0_HIGH_BYTE: read_word[7:0] = bank_regs[bank][0][15:8];
      IDX_DATA_REG_1_LOW_BYTE: read_word[7:0] = bank_regs[bank][1][7:0];
      IDX_DATA_REG_1_HIGH_BYTE: read_word[7:0] = bank_regs[bank][1][15:8];
      IDX_DATA_PAIR_EVEN: read_word = {bank_regs[bank][2], bank_regs[bank][0]};
      IDX_DATA_PAIR_ODD: read_word = {bank_regs[bank][3], bank_regs[bank][1]};
      IDX_ADDRESS_PAIR: read_word = {bank_regs[bank][5], bank_regs[bank][4]};
      IDX_ACTIVE_STACK_POINTER: read_word[15:0] = active_sp;
      default: read_word = 32'h0000_0000;
    endcase
    // Misaligned or out-of-range reads answer zero
    if (reg_addr[1:0] != 2'b00 || reg_addr[7]) begin
      read_word = 32'h0000_0000;
    end
  end

  // Read data stands for exactly one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= read_word;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Views towards the datapath follow the active bank directly
  always_comb begin
    exe_view.data_pair_even = {bank_regs[bank][2], bank_regs[bank][0]};
    exe_view.data_pair_odd = {bank_regs[bank][3], bank_regs[bank][1]};
    exe_view.address_pair = {bank_regs[bank][5], bank_regs[bank][4]};
    exe_view.frame_base = bank_regs[bank][6];
    exe_view.static_base = static_base;
    exe_view.active_sp = active_sp;
    exe_view.vector_table_base = vector_table_base;
    exe_view.program_counter = program_counter;
    exe_view.status_flags = status_flags;
  end

  // Region decode; vector table is checked before the program memory
  // it overlaps, and every 20-bit address lands in some answer
  always_comb begin
    next_region = CRF_REGION_UNMAPPED;
    if (map_addr >= VECTOR_LOW && map_addr <= VECTOR_HIGH) begin
      next_region = CRF_REGION_VECTOR;
    end else if (map_addr >= ROM_LOW && map_addr <= ROM_HIGH) begin
      next_region = CRF_REGION_ROM;
    // data memory from its base up to RAM_HIGH
    end else if (map_addr >= RAM_LOW && map_addr <= RAM_HIGH) begin
      next_region = CRF_REGION_RAM;
    end else if (map_addr <= SFR_HIGH) begin
      next_region = CRF_REGION_SFR;
    // flagged so the debugger range is never granted
    end else if (map_addr >= DEBUG_LOW && map_addr <= DEBUG_HIGH) begin
      next_region = CRF_REGION_DEBUG;
    end
  end

  // Decode answer one cycle after the request, held until the next one
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      map_region <= CRF_REGION_UNMAPPED;
      map_grant <= 1'b0;
    end else if (map_req) begin
      map_region <= next_region;
      map_grant <= (next_region == CRF_REGION_SFR) ? sfr_assigned
                 : (next_region != CRF_REGION_UNMAPPED && next_region != CRF_REGION_DEBUG);
    end
  end

endmodule : crf_core

`default_nettype wire

// *** rtl/crf_pkg.sv ***
/*
  Constants and types shared by the processor core register file:
  register indices, flag bit positions, memory map boundaries and the
  packed carriers between the register file and the execution datapath.
  Assumes one 20 MHz system clock and a synchronous active-high reset.
*/
`default_nettype none

package crf_pkg;

  // Register port: one 32-bit word per register, byte address = index * 4
  localparam int unsigned REG_ADDR_W = 8;
  localparam int unsigned SEL_W = 5;

  localparam logic [4:0] IDX_DATA_REG_0 = 5'h00;
  localparam logic [4:0] IDX_DATA_REG_1 = 5'h01;
  localparam logic [4:0] IDX_DATA_REG_2 = 5'h02;
  localparam logic [4:0] IDX_DATA_REG_3 = 5'h03;
  localparam logic [4:0] IDX_ADDRESS_REG_0 = 5'h04;
  localparam logic [4:0] IDX_ADDRESS_REG_1 = 5'h05;
  localparam logic [4:0] IDX_FRAME_BASE = 5'h06;
  localparam logic [4:0] IDX_STATIC_BASE = 5'h07;
  localparam logic [4:0] IDX_VECTOR_TABLE_BASE = 5'h08;
  localparam logic [4:0] IDX_PROGRAM_COUNTER = 5'h09;
  localparam logic [4:0] IDX_USER_STACK_POINTER = 5'h0a;
  localparam logic [4:0] IDX_INTERRUPT_STACK_POINTER = 5'h0b;
  localparam logic [4:0] IDX_STATUS_FLAGS = 5'h0c;
  localparam logic [4:0] IDX_DATA_REG_0_LOW_BYTE = 5'h0d;
  localparam logic [4:0] IDX_DATA_REG_0_HIGH_BYTE = 5'h0e;
  localparam logic [4:0] IDX_DATA_REG_1_LOW_BYTE = 5'h0f;
  localparam logic [4:0] IDX_DATA_REG_1_HIGH_BYTE = 5'h10;
  localparam logic [4:0] IDX_DATA_PAIR_EVEN = 5'h11;
  localparam logic [4:0] IDX_DATA_PAIR_ODD = 5'h12;
  localparam logic [4:0] IDX_ADDRESS_PAIR = 5'h13;
  localparam logic [4:0] IDX_ACTIVE_STACK_POINTER = 5'h14;

  // Banked registers: data 0..3, address 0..1, frame base
  localparam int unsigned BANKED_COUNT = 7;
  localparam int unsigned BANK_COUNT = 2;

  // Flag register layout
  localparam int unsigned FLAGS_W = 11;
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_DEBUG = 1;
  localparam int unsigned FLAG_ZERO = 2;
  localparam int unsigned FLAG_SIGN = 3;
  localparam int unsigned FLAG_BANK = 4;
  localparam int unsigned FLAG_OVERFLOW = 5;
  localparam int unsigned FLAG_INT_ENABLE = 6;
  localparam int unsigned FLAG_STACK_SEL = 7;

  // Reset values
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [19:0] RESET_ADDR = 20'h0_0000;
  localparam logic [10:0] RESET_FLAGS = 11'h000;

  // Memory map, 20-bit addresses
  localparam logic [19:0] MAP_LOW = 20'h0_0000;
  localparam logic [19:0] MAP_HIGH = 20'hF_FFFF;
  localparam logic [19:0] SFR_LOW = 20'h0_0000;
  localparam logic [19:0] SFR_HIGH = 20'h0_02FF;
  localparam logic [19:0] RAM_LOW = 20'h0_0400;
  localparam logic [19:0] RAM_HIGH = 20'h0_0DFF;
  localparam logic [19:0] ROM_LOW = 20'h0_4000;
  localparam logic [19:0] ROM_HIGH = 20'h0_FFFF;
  localparam logic [19:0] VECTOR_LOW = 20'h0_FFDC;
  localparam logic [19:0] VECTOR_HIGH = 20'h0_FFFF;
  localparam logic [19:0] DEBUG_LOW = 20'h2_0000;
  localparam logic [19:0] DEBUG_HIGH = 20'h2_3FFF;

  typedef enum logic [2:0] {
    CRF_REGION_UNMAPPED,
    CRF_REGION_SFR,
    CRF_REGION_RAM,
    CRF_REGION_ROM,
    CRF_REGION_VECTOR,
    CRF_REGION_DEBUG
  } crf_region_t;

  // Register write from either source
  typedef struct packed {
    logic valid;
    logic [4:0] sel;
    logic [31:0] data;
  } crf_wr_t;

  // Arithmetic result reported by the datapath
  typedef struct packed {
    logic valid;
    logic byte_op;
    logic [15:0] result;
    logic carry;
    logic overflow;
  } crf_alu_t;

  // Views of the active register set towards the datapath
  typedef struct packed {
    logic [31:0] data_pair_even;
    logic [31:0] data_pair_odd;
    logic [31:0] address_pair;
    logic [15:0] frame_base;
    logic [15:0] static_base;
    logic [15:0] active_sp;
    logic [19:0] vector_table_base;
    logic [19:0] program_counter;
    logic [10:0] status_flags;
  } crf_view_t;

endpackage : crf_pkg

`default_nettype wire
